//--- ltil_pkg.sv
// Shared constants and types of the light threshold interrupt block.
// Assumes a byte-wide register map behind a two-wire serial slave port.
package ltil_pkg;

  typedef logic [15:0] ltil_word_t;

  // Register addresses
  localparam logic [3:0] LOW_THRESHOLD_LOW_BYTE_ADDR   = 4'h2;
  localparam logic [3:0] LOW_THRESHOLD_HIGH_BYTE_ADDR  = 4'h3;
  localparam logic [3:0] HIGH_THRESHOLD_LOW_BYTE_ADDR  = 4'h4;
  localparam logic [3:0] HIGH_THRESHOLD_HIGH_BYTE_ADDR = 4'h5;
  localparam logic [3:0] INTERRUPT_CONTROL_ADDR        = 4'h6;
  localparam logic [3:0] PART_REVISION_IDENT_ADDR      = 4'hA;

  // Command word fields
  localparam int CMD_SELECT_BIT = 7;
  localparam int CMD_CLEAR_BIT  = 6;
  localparam int CMD_WORD_BIT   = 5;
  localparam int CMD_ADDR_MSB   = 3;

  // Interrupt control fields
  localparam int MODE_MSB    = 5;
  localparam int MODE_LSB    = 4;
  localparam int PERSIST_MSB = 3;

  // Reset values
  localparam logic [5:0] INT_CTRL_RST = 6'h00;
  localparam ltil_word_t THR_RST      = 16'h0000;
  localparam logic [3:0] PTR_RST      = 4'h0;

  // Bus addresses
  localparam logic [6:0] OWN_SLAVE_ADDR  = 7'h39;
  localparam logic [6:0] ALERT_RESP_ADDR = 7'h0C;

  // Identification, arbitrary values
  localparam logic [3:0] PART_NUMBER_FIELD_VAL      = 4'h5;
  localparam logic [3:0] SILICON_REVISION_FIELD_VAL = 4'h1;

  // Bit counter marks and event slots
  localparam logic [3:0] BIT_LAST    = 4'h7;
  localparam logic [3:0] BIT_ACK     = 4'h8;
  localparam logic [3:0] PERSIST_MAX = 4'hF;
  localparam int         EV_WR       = 2;
  localparam int         EV_CLR      = 1;
  localparam int         EV_ARA      = 0;

  typedef enum logic [1:0] {
    MODE_OFF   = 2'h0,
    MODE_LEVEL = 2'h1,
    MODE_ALERT = 2'h2,
    MODE_TEST  = 2'h3
  } ltil_mode_e;

  typedef enum logic [2:0] {
    LS_IDLE  = 3'h0,
    LS_ADDR  = 3'h1,
    LS_CMD   = 3'h3,
    LS_WDATA = 3'h2,
    LS_TXREG = 3'h6,
    LS_TXARA = 3'h7
  } ltil_lstate_e;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] data;
  } ltil_wreq_s;

  typedef struct packed {
    ltil_lstate_e st;
    logic [3:0]   cnt;
    logic [7:0]   sh;
    logic [7:0]   tx;
    logic         rw;
    logic         ack;
    logic         ara;
    logic [3:0]   ptr;
    logic         word;
    logic         drive;
    logic         start_seen;
    logic         wr_tgl;
    logic         clr_tgl;
    logic         ara_tgl;
    ltil_wreq_s   wreq;
  } ltil_link_s;

  typedef struct packed {
    ltil_word_t thr_lo;
    ltil_word_t thr_hi;
    logic [1:0] irq_output_mode;
    logic [3:0] persist;
    logic [3:0] run_cnt;
    logic       pending;
    logic       irq_n;
    logic       alert_req;
    logic [2:0] evt_seen;
  } ltil_core_s;

  localparam ltil_core_s CORE_RST = '{
    thr_lo:          THR_RST,
    thr_hi:          THR_RST,
    irq_output_mode: INT_CTRL_RST[MODE_MSB:MODE_LSB],
    persist:         INT_CTRL_RST[PERSIST_MSB:0],
    run_cnt:         4'h0,
    pending:         1'b0,
    irq_n:           1'b1,
    alert_req:       1'b0,
    evt_seen:        3'h0
  };

  localparam ltil_link_s LINK_RST = '{
    st:      LS_IDLE,
    ptr:     PTR_RST,
    default: '0
  };

endpackage

//--- ltil_sync.sv
// Three-flop synchroniser with an agreement filter, one lane per bit.
// Assumes each bit is a slow level or toggle; lanes are independent.
`timescale 1ns/10ps

module ltil_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         arst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  import ltil_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } ltil_sync_s;

  ltil_sync_s st_q;
  ltil_sync_s st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < W; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.q[i] = st_q.s3[i];
      end
    end
  end

  always_ff @(posedge clk or posedge arst) begin
    if (arst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.q;

endmodule // ltil_sync

//--- ltil_top.sv
// Light threshold interrupt logic: two-wire register slave, window
// compare on channel 0, persistence filter and interrupt line driver.
// Assumes ch0_data and conv_done come from the converter on core_clk,
// and the bus clock arrives on scl_clk with the bus idle during reset.
//
// Overview of operation
// - Result at or below low threshold is outside.
// - Result above high threshold is outside.
// - Thresholds live at byte addresses 2h to 5h.
// - Only channel 0 feeds the comparison.
// - Command byte with top bit set sets pointer.
// - Command bit 7 set; bits 3:0 address.
// - Persistence zero interrupts every integration cycle.
// - Persistence one interrupts on any outside result.
// - Persistence N needs N consecutive outside results.
// - Mode field selects off, level, alert, test.
// - Level mode holds line low until clear.
// - Clear bit clears pending, never stored.
// - Alert response returns own address, then releases.
// - Lost arbitration leaves the interrupt pending.
// - Writing test mode sets interrupt, acts as alert.
// - Identification register is constant part and revision.
`timescale 1ns/10ps

module ltil_top (
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  input  wire logic                 scl_clk,
  input  wire logic                 sda_line,
  output logic                      sda_data,
  output logic                      sda_oe,
  input  wire ltil_pkg::ltil_word_t ch0_data,
  input  wire logic                 conv_done,
  output logic                      irq_n
);
  import ltil_pkg::*;

  ltil_core_s core_q;
  ltil_core_s core_d;
  ltil_link_s link_q;
  ltil_link_s link_d;
  logic       start_tgl_q;
  logic       sda_oe_q;
  logic       sda_data_q;
  logic [2:0] evt_sync;
  logic       alert_sync;

  // Events from the link into the core domain
  ltil_sync #(
    .W (3)
  ) u_evt_sync (
    .clk  (core_clk),
    .arst (sys_rst),
    .d    ({link_q.wr_tgl, link_q.clr_tgl, link_q.ara_tgl}),
    .q    (evt_sync)
  );

  // Alert request level into the link domain
  ltil_sync #(
    .W (1)
  ) u_alert_sync (
    .clk  (scl_clk),
    .arst (sys_rst),
    .d    (core_q.alert_req),
    .q    (alert_sync)
  );

  // Register read mux; core fields are quasi-static between link writes
  function automatic logic [7:0] read_byte(input logic [3:0] addr);
    logic [7:0] val;
    val = 8'h00;
    case (addr)
      LOW_THRESHOLD_LOW_BYTE_ADDR: begin
        val = core_q.thr_lo[7:0];
      end
      LOW_THRESHOLD_HIGH_BYTE_ADDR: begin
        val = core_q.thr_lo[15:8];
      end
      HIGH_THRESHOLD_LOW_BYTE_ADDR: begin
        val = core_q.thr_hi[7:0];
      end
      HIGH_THRESHOLD_HIGH_BYTE_ADDR: begin
        val = core_q.thr_hi[15:8];
      end
      INTERRUPT_CONTROL_ADDR: begin
        val = {2'h0, core_q.irq_output_mode, core_q.persist};
      end
      PART_REVISION_IDENT_ADDR: begin
        val = {PART_NUMBER_FIELD_VAL, SILICON_REVISION_FIELD_VAL};
      end
      default: begin
        val = 8'h00;
      end
    endcase
    return val;
  endfunction

  // Start condition: data falls while the bus clock is high
  always_ff @(negedge sda_line or posedge sys_rst) begin
    if (sys_rst) begin
      start_tgl_q <= 1'b0;
    end else if (scl_clk) begin
      start_tgl_q <= ~start_tgl_q;
    end
  end

  // Link protocol, sampled on the rising bus clock
  always_comb begin
    logic [7:0] rx;
    logic       hit_own;
    logic       hit_ara;
    logic [7:0] nxt_tx;
    logic [3:0] nxt_ptr;
    rx      = {link_q.sh[6:0], sda_line};
    hit_own = rx[7:1] == OWN_SLAVE_ADDR;
    hit_ara = (rx[7:1] == ALERT_RESP_ADDR) && rx[0] && alert_sync;
    nxt_tx  = {link_q.tx[6:0], 1'b0};
    nxt_ptr = link_q.ptr;
    if (link_q.word) begin
      nxt_ptr = link_q.ptr + 4'h1;
    end
    link_d  = link_q;
    link_d.start_seen = start_tgl_q;
    if (start_tgl_q != link_q.start_seen) begin
      link_d.st    = LS_ADDR;
      link_d.sh    = rx;
      link_d.cnt   = 4'h1;
      link_d.drive = 1'b0;
    end else begin
      case (link_q.st)
        // Receive states share one shifter
        LS_ADDR, LS_CMD, LS_WDATA: begin
          if (link_q.cnt < BIT_LAST) begin
            link_d.sh  = rx;
            link_d.cnt = link_q.cnt + 4'h1;
          end else if (link_q.cnt == BIT_LAST) begin
            link_d.sh    = rx;
            link_d.cnt   = BIT_ACK;
            link_d.drive = 1'b1;
            case (link_q.st)
              LS_ADDR: begin
                link_d.ack   = hit_own || hit_ara;
                link_d.drive = hit_own || hit_ara;
                link_d.rw    = rx[0];
                link_d.ara   = hit_ara;
              end
              LS_CMD: begin
                link_d.ack = rx[CMD_SELECT_BIT];
                if (rx[CMD_SELECT_BIT]) begin
                  link_d.ptr  = rx[CMD_ADDR_MSB:0];
                  link_d.word = rx[CMD_WORD_BIT];
                  if (rx[CMD_CLEAR_BIT]) begin
                    link_d.clr_tgl = ~link_q.clr_tgl;
                  end
                end
              end
              default: begin
                link_d.wreq.addr = link_q.ptr;
                link_d.wreq.data = rx;
                link_d.wr_tgl    = ~link_q.wr_tgl;
                link_d.ptr       = nxt_ptr;
              end
            endcase
          end else begin
            // Acknowledge bit, then pick the next phase
            link_d.cnt   = 4'h0;
            link_d.drive = 1'b0;
            if (link_q.st == LS_ADDR) begin
              if (!link_q.ack) begin
                link_d.st = LS_IDLE;
              end else if (link_q.ara) begin
                link_d.st    = LS_TXARA;
                link_d.tx    = {OWN_SLAVE_ADDR, 1'b0};
                link_d.drive = ~OWN_SLAVE_ADDR[6];
              end else if (link_q.rw) begin
                link_d.st    = LS_TXREG;
                link_d.tx    = read_byte(link_q.ptr);
                link_d.drive = ~link_d.tx[7];
              end else begin
                link_d.st = LS_CMD;
              end
            end else if (link_q.st == LS_CMD) begin
              if (link_q.ack) begin
                link_d.st = LS_WDATA;
              end else begin
                link_d.st = LS_IDLE;
              end
            end
          end
        end
        // Transmit, checking arbitration on every released bit
        LS_TXREG, LS_TXARA: begin
          if (link_q.cnt <= BIT_LAST) begin
            if (link_q.tx[7] && !sda_line) begin
              link_d.st    = LS_IDLE;
              link_d.drive = 1'b0;
            end else begin
              link_d.tx    = nxt_tx;
              link_d.cnt   = link_q.cnt + 4'h1;
              link_d.drive = 1'b0;
              if (link_q.cnt < BIT_LAST) begin
                link_d.drive = !nxt_tx[7];
              end
              if ((link_q.cnt == BIT_LAST) && (link_q.st == LS_TXARA)) begin
                link_d.ara_tgl = ~link_q.ara_tgl;
              end
            end
          end else begin
            link_d.cnt = 4'h0;
            if (sda_line || (link_q.st == LS_TXARA)) begin
              link_d.st    = LS_IDLE;
              link_d.drive = 1'b0;
            end else begin
              link_d.ptr   = nxt_ptr;
              link_d.tx    = read_byte(nxt_ptr);
              link_d.drive = ~link_d.tx[7];
            end
          end
        end
        default: begin
          link_d.drive = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge scl_clk or posedge sys_rst) begin
    if (sys_rst) begin
      link_q <= LINK_RST;
    end else begin
      link_q <= link_d;
    end
  end

  // Data line changes only while the bus clock is low
  always_ff @(negedge scl_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sda_oe_q   <= 1'b0;
      sda_data_q <= 1'b0;
    end else begin
      sda_oe_q   <= link_q.drive;
      sda_data_q <= 1'b0;
    end
  end

  // Register file, threshold window and interrupt state
  always_comb begin
    logic       wr_ev;
    logic       clr_ev;
    logic       ara_ev;
    logic       out_win;
    logic       below_lo;
    logic       above_hi;
    logic       irq_on;
    logic       fire;
    logic       test_set;
    logic [3:0] next_cnt;
    wr_ev    = evt_sync[EV_WR] != core_q.evt_seen[EV_WR];
    clr_ev   = evt_sync[EV_CLR] != core_q.evt_seen[EV_CLR];
    ara_ev   = evt_sync[EV_ARA] != core_q.evt_seen[EV_ARA];
    below_lo = ch0_data <= core_q.thr_lo;
    above_hi = ch0_data > core_q.thr_hi;
    out_win  = below_lo || above_hi;
    fire     = 1'b0;
    test_set = 1'b0;
    next_cnt = 4'h0;
    irq_on   = 1'b0;
    core_d   = core_q;
    core_d.evt_seen = evt_sync;
    // Register writes from the link
    if (wr_ev) begin
      case (link_q.wreq.addr)
        LOW_THRESHOLD_LOW_BYTE_ADDR: begin
          core_d.thr_lo[7:0] = link_q.wreq.data;
        end
        LOW_THRESHOLD_HIGH_BYTE_ADDR: begin
          core_d.thr_lo[15:8] = link_q.wreq.data;
        end
        HIGH_THRESHOLD_LOW_BYTE_ADDR: begin
          core_d.thr_hi[7:0] = link_q.wreq.data;
        end
        HIGH_THRESHOLD_HIGH_BYTE_ADDR: begin
          core_d.thr_hi[15:8] = link_q.wreq.data;
        end
        INTERRUPT_CONTROL_ADDR: begin
          core_d.irq_output_mode = link_q.wreq.data[MODE_MSB:MODE_LSB];
          core_d.persist         = link_q.wreq.data[PERSIST_MSB:0];
          test_set = link_q.wreq.data[MODE_MSB:MODE_LSB] == MODE_TEST;
        end
        default: begin
          test_set = 1'b0;
        end
      endcase
    end
    // Persistence counter, saturating
    if (conv_done) begin
      if (!out_win) begin
        next_cnt = 4'h0;
      end else if (core_q.run_cnt != PERSIST_MAX) begin
        next_cnt = core_q.run_cnt + 4'h1;
      end else begin
        next_cnt = PERSIST_MAX;
      end
      core_d.run_cnt = next_cnt;
      if (core_q.persist == 4'h0) begin
        fire = 1'b1;
      end else begin
        fire = out_win && (next_cnt >= core_q.persist);
      end
    end
    // Host clear or alert response
    if (clr_ev || ara_ev) begin
      core_d.pending = 1'b0;
    end
    // Set wins over a clear in the same cycle
    if ((fire && (core_q.irq_output_mode != MODE_OFF)) || test_set) begin
      core_d.pending = 1'b1;
    end
    irq_on           = core_d.pending && (core_d.irq_output_mode != MODE_OFF);
    core_d.irq_n     = !irq_on;
    core_d.alert_req = core_d.pending && core_d.irq_output_mode[1];
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      core_q <= CORE_RST;
    end else begin
      core_q <= core_d;
    end
  end

  // Outputs straight from flops
  assign irq_n    = core_q.irq_n;
  assign sda_oe   = sda_oe_q;
  assign sda_data = sda_data_q;

endmodule // ltil_top

//--- ltil_chk_assertions.sv
// Port checker for the light threshold interrupt block.
// Assumes the host keeps scl moving inside frames and high between them.
`timescale 1ns/10ps
module ltil_chk (
  input wire logic                 core_clk,
  input wire logic                 sys_rst,
  input wire logic                 scl_clk,
  input wire logic                 sda_line,
  input wire logic                 sda_data,
  input wire logic                 sda_oe,
  input wire ltil_pkg::ltil_word_t ch0_data,
  input wire logic                 conv_done,
  input wire logic                 irq_n
);
  import ltil_pkg::*;
  logic [7:0] idle_q;
  logic [7:0] idle_d;

  // Core cycles since scl was last seen low
  always_comb idle_d = !scl_clk ? 8'h00 : idle_q + {7'h00, idle_q != 8'hFF};
  always_ff @(posedge core_clk) idle_q <= sys_rst ? 8'h00 : idle_d;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  chk_data_low: assert property (sda_data == 1'b0)
    else $error("sda_data driven high");
  chk_rst_quiet: assert property (disable iff (1'b0) sys_rst |=> irq_n)
    else $error("irq_n low after reset");
  chk_rst_oe: assert property (disable iff (1'b0) sys_rst |-> !sda_oe)
    else $error("sda_oe high in reset");
  chk_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_clk)
    else $error("sda_oe moved while scl high");
  chk_oe_hold: assert property ($rose(sda_oe) |-> sda_oe [*3])
    else $error("sda_oe bit too short");
  chk_oe_released: assert property (sda_oe |-> idle_q < 8'd20)
    else $error("sda_oe held outside frame");
  chk_irq_rise_bus: assert property ($rose(irq_n) |-> idle_q < 8'd20)
    else $error("irq_n released without host");
  chk_irq_fall_cause: assert property ($fell(irq_n) |->
      $past(conv_done) || $past(conv_done, 2) || idle_q < 8'd20)
    else $error("irq_n fell without cause");

  cov_irq_fall: cover property ($fell(irq_n));
  cov_irq_rise: cover property ($rose(irq_n));
  cov_oe_rise: cover property ($rose(sda_oe));
endmodule // ltil_chk

bind ltil_top ltil_chk ltil_chk_i (.core_clk(core_clk), .sys_rst(sys_rst),
  .scl_clk(scl_clk), .sda_line(sda_line), .sda_data(sda_data), .sda_oe(sda_oe),
  .ch0_data(ch0_data), .conv_done(conv_done), .irq_n(irq_n));

//--- ltil_host.sv
// Two-wire bus master model facing the threshold block.
// Assumes a pull-up on the data wire; scl stands high between frames.
`timescale 1ns/10ps
module ltil_host (
  output logic      scl,
  output logic      pull_lo,
  input  wire logic sda
);
  import ltil_pkg::*;

  initial begin
    scl     = 1'b1;
    pull_lo = 1'b0;
  end

  task automatic start();
    pull_lo = 1'b0;
    #20 scl = 1'b1;
    #20 pull_lo = 1'b1;
    #20 scl = 1'b0;
  endtask

  task automatic stop();
    pull_lo = 1'b1;
    #20 scl = 1'b1;
    #20 pull_lo = 1'b0;
  endtask

  // Eight bits plus acknowledge, 80 ns per bit
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      pull_lo = !tx[i];
      #20 scl = 1'b1;
      #20 rx[i] = sda;
      #20 scl = 1'b0;
      #20;
    end
  endtask

  // Command with n data bytes, low byte first
  task automatic wr(input logic [7:0] cmd, input logic [15:0] dat, input int n);
    logic [8:0] rx;
    start();
    xfer({OWN_SLAVE_ADDR, 1'b0, 1'b1}, rx);
    xfer({cmd, 1'b1}, rx);
    for (int i = 0; i < n; i++) xfer({dat[8*i +: 8], 1'b1}, rx);
    stop();
  endtask

  task automatic rd(input logic [7:0] cmd, output logic [7:0] d);
    logic [8:0] rx;
    start();
    xfer({OWN_SLAVE_ADDR, 1'b0, 1'b1}, rx);
    xfer({cmd, 1'b1}, rx);
    start();
    xfer({OWN_SLAVE_ADDR, 1'b1, 1'b1}, rx);
    xfer(9'h1FF, rx);
    d = rx[8:1];
    stop();
  endtask

  // Alert response read; rival bits model a competing device
  task automatic ara(input logic [7:0] rival, output logic ack, output logic [7:0] d);
    logic [8:0] rx;
    start();
    xfer({ALERT_RESP_ADDR, 1'b1, 1'b1}, rx);
    ack = !rx[0];
    d = 8'h00;
    if (ack) begin
      xfer({rival, 1'b1}, rx);
      d = rx[8:1];
    end
    stop();
  endtask
endmodule // ltil_host

//--- tb.sv
// Self-checking bench of the light threshold interrupt block.
// Assumes the host model is the only bus master.
`timescale 1ns/10ps
module tb;
  import ltil_pkg::*;
  logic       core_clk;
  logic       sys_rst;
  logic       scl_clk;
  logic       pull_lo;
  logic       sda_line;
  logic       sda_data;
  logic       sda_oe;
  ltil_word_t ch0_data;
  logic       conv_done;
  logic       irq_n;
  int         errors;
  int         num_checks;
  logic       ack;
  logic [7:0] d;
  logic [3:0] pn [3] = '{4'h1, 4'h2, 4'hF};

  assign sda_line = !(sda_oe | pull_lo);

  ltil_top ltil_top_i (.core_clk(core_clk), .sys_rst(sys_rst), .scl_clk(scl_clk),
    .sda_line(sda_line), .sda_data(sda_data), .sda_oe(sda_oe), .ch0_data(ch0_data),
    .conv_done(conv_done), .irq_n(irq_n));
  ltil_host ltil_host_i (.scl(scl_clk), .pull_lo(pull_lo), .sda(sda_line));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = !core_clk;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_core(input int n);
    repeat (n) @(posedge core_clk);
    #3;
  endtask

  task automatic irq_chk(input logic e);
    check("irq_n", {7'h00, irq_n}, {7'h00, e});
  endtask

  // One integration result on channel 0
  task automatic conv(input ltil_word_t v);
    @(posedge core_clk);
    ch0_data  <= v;
    conv_done <= 1'b1;
    @(posedge core_clk);
    conv_done <= 1'b0;
    wait_core(3);
  endtask

  task automatic wr_ctl(input logic [7:0] v);
    ltil_host_i.wr(8'h86, {8'h00, v}, 1);
    wait_core(8);
  endtask

  task automatic clr();
    ltil_host_i.wr(8'hC6, 16'h0000, 0);
    wait_core(8);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #1500000;
    errors++;
    wrap_up();
  end

  initial begin
    errors     = 0;
    num_checks = 0;
    sys_rst    = 1'b1;
    ch0_data   = 16'h0000;
    conv_done  = 1'b0;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    wait_core(2);
    irq_chk(1'b1);
    ltil_host_i.rd(8'h86, d);
    check("control", d, 8'h00);
    ltil_host_i.rd(8'h8A, d);
    check("ident", d, {PART_NUMBER_FIELD_VAL, SILICON_REVISION_FIELD_VAL});
    ltil_host_i.wr(8'h8A, 16'h00FF, 1);
    ltil_host_i.rd(8'h8A, d);
    check("ident", d, {PART_NUMBER_FIELD_VAL, SILICON_REVISION_FIELD_VAL});
    ltil_host_i.wr(8'hA2, 16'h0100, 2);
    ltil_host_i.wr(8'hA4, 16'h0200, 2);
    ltil_host_i.rd(8'h83, d);
    check("low thr high", d, 8'h01);
    ltil_host_i.rd(8'h84, d);
    check("high thr low", d, 8'h00);
    $display("test registers done");
    wr_ctl(8'h11);
    conv(16'h0101);
    irq_chk(1'b1);
    conv(16'h0100);
    irq_chk(1'b0);
    conv(16'h0150);
    wait_core(40);
    irq_chk(1'b0);
    clr();
    irq_chk(1'b1);
    ltil_host_i.rd(8'h86, d);
    check("control", d, 8'h11);
    conv(16'h0201);
    irq_chk(1'b0);
    clr();
    conv(16'h0200);
    irq_chk(1'b1);
    $display("test window done");
    foreach (pn[k]) begin
      wr_ctl({4'h1, pn[k]});
      conv(16'h0150);
      clr();
      repeat (int'(pn[k]) - 1) conv(16'h0300);
      conv(16'h0150);
      repeat (int'(pn[k]) - 1) conv(16'h0300);
      irq_chk(1'b1);
      conv(16'h0300);
      irq_chk(1'b0);
      clr();
    end
    wr_ctl(8'h10);
    conv(16'h0150);
    irq_chk(1'b0);
    clr();
    $display("test persistence done");
    wr_ctl(8'h01);
    conv(16'h0300);
    irq_chk(1'b1);
    wr_ctl(8'h21);
    ltil_host_i.ara(8'hFF, ack, d);
    check("ara ack", {7'h00, ack}, 8'h00);
    conv(16'h0300);
    irq_chk(1'b0);
    ltil_host_i.ara(8'h40, ack, d);
    wait_core(8);
    irq_chk(1'b0);
    ltil_host_i.ara(8'hFF, ack, d);
    wait_core(8);
    check("ara byte", d, {OWN_SLAVE_ADDR, 1'b0});
    irq_chk(1'b1);
    $display("test alert done");
    wr_ctl(8'h30);
    irq_chk(1'b0);
    ltil_host_i.ara(8'hFF, ack, d);
    wait_core(8);
    irq_chk(1'b1);
    $display("test software set done");
    wrap_up();
  end
endmodule // tb
